// ---- rtl/tsc_top.sv ----
// thermal sense control: register file, interrupt and conversion front end
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module tsc_top (
  // clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        resetn_i,
  // register port
  input  wire logic [tsc_pkg::TSC_ADDR_W-1:0] addr_i,
  input  wire logic [tsc_pkg::TSC_DATA_W-1:0] wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic [tsc_pkg::TSC_DATA_W-1:0]   rdata_o,
  // oscillator pins
  input  wire logic                        fast_osc_a_i,
  input  wire logic                        fast_osc_b_i,
  input  wire logic                        slow_osc_i,
  // analog sensing element
  input  wire logic [7:0]                  sense_data_i,
  output logic                             sense_power_o,
  output logic                             sense_sample_o,
  // interrupt
  output logic                             irq_o
);
  import tsc_pkg::*;

  // address decode
  logic hit_clock;
  logic hit_compare;
  logic hit_control;
  logic hit_status;
  logic hit_result;
  logic wr_clock;
  logic wr_compare;
  logic wr_control;
  logic wr_status;

  // clock control state
  logic [1:0] sense_clock_divider_reg;
  logic [1:0] sense_clock_divider_next;
  logic [1:0] sense_clock_source_reg;
  logic [1:0] sense_clock_source_next;
  logic       sense_clock_gate_reg;
  logic       sense_clock_gate_next;

  // comparison time state
  logic [7:0] comparison_cycles_reg;
  logic [7:0] comparison_cycles_next;

  // control state
  logic       completion_irq_enable_reg;
  logic       completion_irq_enable_next;
  logic       sensor_enable_reg;
  logic       sensor_enable_next;

  // status state
  logic       completion_flag_reg;
  logic       completion_flag_next;

  // read path
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // sensor data synchroniser
  logic [7:0] data_meta_reg;
  logic [7:0] data_sync_reg;

  // internal links
  logic       sense_tick;
  logic       conversion_trigger;
  logic       conv_abort;
  logic       conversion_busy;
  logic       conv_done;
  logic [7:0] conv_result;

  // decode
  always_comb begin
    hit_clock   = (addr_i == TSC_OFF_CLOCK_CTRL);
    hit_compare = (addr_i == TSC_OFF_COMPARE_TIM);
    hit_control = (addr_i == TSC_OFF_CONTROL);
    hit_status  = (addr_i == TSC_OFF_STATUS);
    hit_result  = (addr_i == TSC_OFF_RESULT);
    wr_clock    = wr_i && hit_clock;
    wr_compare  = wr_i && hit_compare;
    wr_control  = wr_i && hit_control;
    wr_status   = wr_i && hit_status;
  end

  // clock control register
  always_comb begin
    sense_clock_divider_next = sense_clock_divider_reg;
    sense_clock_source_next  = sense_clock_source_reg;
    sense_clock_gate_next    = sense_clock_gate_reg;
    if (wr_clock) begin
      sense_clock_divider_next = wdata_i[TSC_CLK_DIV_MSB:TSC_CLK_DIV_LSB];
      sense_clock_source_next  = wdata_i[TSC_CLK_SRC_MSB:TSC_CLK_SRC_LSB];
      sense_clock_gate_next    = wdata_i[TSC_CLK_GATE_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sense_clock_divider_reg <= TSC_CLK_DIV_RST;
      sense_clock_source_reg  <= TSC_CLK_SRC_RST;
      sense_clock_gate_reg    <= TSC_CLK_GATE_RST;
    end else begin
      sense_clock_divider_reg <= sense_clock_divider_next;
      sense_clock_source_reg  <= sense_clock_source_next;
      sense_clock_gate_reg    <= sense_clock_gate_next;
    end
  end

  // comparison time register
  always_comb begin
    comparison_cycles_next = comparison_cycles_reg;
    if (wr_compare) begin
      comparison_cycles_next = wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      comparison_cycles_reg <= TSC_COMPARE_RST;
    end else begin
      comparison_cycles_reg <= comparison_cycles_next;
    end
  end

  // control register
  always_comb begin
    completion_irq_enable_next = completion_irq_enable_reg;
    sensor_enable_next         = sensor_enable_reg;
    if (wr_control) begin
      completion_irq_enable_next = wdata_i[TSC_CTL_IE_BIT];
      sensor_enable_next         = wdata_i[TSC_CTL_EN_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      completion_irq_enable_reg <= TSC_CTL_IE_RST;
      sensor_enable_reg         <= TSC_CTL_EN_RST;
    end else begin
      completion_irq_enable_reg <= completion_irq_enable_next;
      sensor_enable_reg         <= sensor_enable_next;
    end
  end

  // trigger and abort; enable may be set in the same write
  always_comb begin
    conversion_trigger = wr_control && wdata_i[TSC_CTL_TRG_BIT] &&
                         wdata_i[TSC_CTL_EN_BIT] && sense_clock_gate_reg;
    // abort follows the value being written, so enable plus trigger may start
    conv_abort         = !sensor_enable_next || !sense_clock_gate_next;
  end

  // completion flag, set beats clear
  always_comb begin
    completion_flag_next = completion_flag_reg;
    if (wr_status && wdata_i[TSC_STAT_FLAG_BIT]) begin
      completion_flag_next = 1'b0;
    end
    if (conv_done) begin
      completion_flag_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      completion_flag_reg <= TSC_FLAG_RST;
    end else begin
      completion_flag_reg <= completion_flag_next;
    end
  end

  // sensor data synchroniser
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_data_sync
      always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
          data_meta_reg[g] <= 1'b0;
          data_sync_reg[g] <= 1'b0;
        end else begin
          data_meta_reg[g] <= sense_data_i[g];
          data_sync_reg[g] <= data_meta_reg[g];
        end
      end
    end
  endgenerate

  // read data, one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      if (hit_clock) begin
        rdata_next[TSC_CLK_DIV_MSB:TSC_CLK_DIV_LSB] = sense_clock_divider_reg;
        rdata_next[TSC_CLK_SRC_MSB:TSC_CLK_SRC_LSB] = sense_clock_source_reg;
        rdata_next[TSC_CLK_GATE_BIT]                = sense_clock_gate_reg;
      end else if (hit_compare) begin
        rdata_next = comparison_cycles_reg;
      end else if (hit_control) begin
        rdata_next[TSC_CTL_IE_BIT] = completion_irq_enable_reg;
        rdata_next[TSC_CTL_EN_BIT] = sensor_enable_reg;
      end else if (hit_status) begin
        rdata_next[TSC_STAT_FLAG_BIT] = completion_flag_reg;
        rdata_next[TSC_STAT_BUSY_BIT] = conversion_busy;
      end else if (hit_result) begin
        rdata_next = conv_result;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rdata_reg <= TSC_RDATA_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // sense clock generation
  tsc_clkgen u_clkgen (
    .mclk_i                (mclk_i),
    .resetn_i              (resetn_i),
    .fast_osc_a_i          (fast_osc_a_i),
    .fast_osc_b_i          (fast_osc_b_i),
    .slow_osc_i            (slow_osc_i),
    .sense_clock_source_i  (sense_clock_source_reg),
    .sense_clock_divider_i (sense_clock_divider_reg),
    .sense_clock_gate_i    (sense_clock_gate_reg),
    .tick_o                (sense_tick)
  );

  // conversion sequencer
  tsc_conv u_conv (
    .mclk_i              (mclk_i),
    .resetn_i            (resetn_i),
    .start_i             (conversion_trigger),
    .abort_i             (conv_abort),
    .tick_i              (sense_tick),
    .comparison_cycles_i (comparison_cycles_reg),
    .sample_i            (data_sync_reg),
    .busy_o              (conversion_busy),
    .done_o              (conv_done),
    .result_o            (conv_result)
  );

  // outputs
  assign rdata_o        = rdata_reg;
  assign irq_o          = completion_irq_enable_reg && completion_flag_reg;
  assign sense_power_o  = sensor_enable_reg;
  assign sense_sample_o = conversion_busy;

endmodule // tsc_top

// ---- shared/tsc_pkg.sv ----
// constants and types for the thermal sense control block
package tsc_pkg;

  // bus widths
  localparam int unsigned TSC_ADDR_W = 16;
  localparam int unsigned TSC_DATA_W = 8;

  // register offsets
  localparam logic [15:0] TSC_OFF_CLOCK_CTRL  = 16'h506F;
  localparam logic [15:0] TSC_OFF_COMPARE_TIM = 16'h51A0;
  localparam logic [15:0] TSC_OFF_CONTROL     = 16'h51A1;
  localparam logic [15:0] TSC_OFF_STATUS      = 16'h51A2;
  localparam logic [15:0] TSC_OFF_RESULT      = 16'h51A3;

  // clock control fields
  localparam int unsigned TSC_CLK_GATE_BIT = 0;
  localparam int unsigned TSC_CLK_SRC_LSB  = 2;
  localparam int unsigned TSC_CLK_SRC_MSB  = 3;
  localparam int unsigned TSC_CLK_DIV_LSB  = 4;
  localparam int unsigned TSC_CLK_DIV_MSB  = 5;

  // control fields
  localparam int unsigned TSC_CTL_EN_BIT  = 0;
  localparam int unsigned TSC_CTL_TRG_BIT = 1;
  localparam int unsigned TSC_CTL_IE_BIT  = 4;

  // status fields
  localparam int unsigned TSC_STAT_BUSY_BIT = 0;
  localparam int unsigned TSC_STAT_FLAG_BIT = 4;

  // reset values
  localparam logic [1:0] TSC_CLK_DIV_RST  = 2'h0;
  localparam logic [1:0] TSC_CLK_SRC_RST  = 2'h0;
  localparam logic       TSC_CLK_GATE_RST = 1'h0;
  localparam logic [7:0] TSC_COMPARE_RST  = 8'h00;
  localparam logic       TSC_CTL_EN_RST   = 1'h0;
  localparam logic       TSC_CTL_IE_RST   = 1'h0;
  localparam logic       TSC_FLAG_RST     = 1'h0;
  localparam logic [7:0] TSC_RESULT_RST   = 8'h00;
  localparam logic [7:0] TSC_RDATA_RST    = 8'h00;

  // clock source codes
  localparam logic [1:0] TSC_SRC_FAST_B = 2'h0;
  localparam logic [1:0] TSC_SRC_SLOW   = 2'h1;
  localparam logic [1:0] TSC_SRC_FAST_A = 2'h2;
  localparam logic [1:0] TSC_SRC_RSVD   = 2'h3;

  // divider codes and terminal counts
  localparam logic [1:0] TSC_DIV_1    = 2'h0;
  localparam logic [1:0] TSC_DIV_2    = 2'h1;
  localparam logic [1:0] TSC_DIV_4    = 2'h2;
  localparam logic [1:0] TSC_DIV_1_TC = 2'h0;
  localparam logic [1:0] TSC_DIV_2_TC = 2'h1;
  localparam logic [1:0] TSC_DIV_4_TC = 2'h3;

  // conversion states
  typedef enum logic {TSC_IDLE, TSC_RUN} tsc_state_t;

endpackage

// ---- rtl/tsc_clkgen.sv ----
// oscillator selection, synchronisation and division into sense clock ticks
`timescale 1ns/1ps
module tsc_clkgen (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // oscillator pins
  input  wire logic       fast_osc_a_i,
  input  wire logic       fast_osc_b_i,
  input  wire logic       slow_osc_i,
  // settings
  input  wire logic [1:0] sense_clock_source_i,
  input  wire logic [1:0] sense_clock_divider_i,
  input  wire logic       sense_clock_gate_i,
  // divided tick
  output logic            tick_o
);
  import tsc_pkg::*;

  logic [2:0] osc_raw;
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] prev_reg;
  logic [2:0] rise;
  logic       sel_rise;
  logic       fast_src;
  logic [1:0] limit;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       tick_reg;
  logic       tick_next;

  // index equals source code
  assign osc_raw = {fast_osc_a_i, slow_osc_i, fast_osc_b_i};

  // two-stage synchroniser per oscillator
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= osc_raw[g];
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
        end
      end
      assign rise[g] = sync_reg[g] & ~prev_reg[g];
    end
  endgenerate

  always_comb begin
    sel_rise = 1'b0;
    if (sense_clock_source_i != TSC_SRC_RSVD) begin
      sel_rise = rise[sense_clock_source_i];
    end
    fast_src = (sense_clock_source_i == TSC_SRC_FAST_A) ||
               (sense_clock_source_i == TSC_SRC_FAST_B);
    unique case (sense_clock_divider_i)
      TSC_DIV_2: limit = TSC_DIV_2_TC;
      TSC_DIV_4: limit = TSC_DIV_4_TC;
      default:   limit = TSC_DIV_1_TC;
    endcase
    if (!fast_src) begin
      limit = TSC_DIV_1_TC;
    end
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!sense_clock_gate_i) begin
      cnt_next = 2'h0;
    end else if (sel_rise) begin
      if (cnt_reg >= limit) begin
        cnt_next  = 2'h0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt_reg  <= 2'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule // tsc_clkgen

// ---- rtl/tsc_conv.sv ----
// conversion sequencer: counts comparison ticks and latches the result
`timescale 1ns/1ps
module tsc_conv (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // control
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic       tick_i,
  input  wire logic [7:0] comparison_cycles_i,
  input  wire logic [7:0] sample_i,
  // status
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      result_o
);
  import tsc_pkg::*;

  tsc_state_t state_reg;
  tsc_state_t state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] len_reg;
  logic [7:0] len_next;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic       done_next;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    len_next    = len_reg;
    result_next = result_reg;
    done_next   = 1'b0;
    unique case (state_reg)
      TSC_IDLE: begin
        if (start_i && !abort_i) begin
          state_next = TSC_RUN;
          cnt_next   = 8'h00;
          len_next   = comparison_cycles_i;
        end
      end
      TSC_RUN: begin
        if (abort_i) begin
          state_next = TSC_IDLE;
        end else if (tick_i) begin
          if (cnt_reg == len_reg) begin
            state_next  = TSC_IDLE;
            result_next = sample_i;
            done_next   = 1'b1;
          end else begin
            cnt_next = cnt_reg + 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_reg  <= TSC_IDLE;
      cnt_reg    <= 8'h00;
      len_reg    <= 8'h00;
      result_reg <= TSC_RESULT_RST;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      len_reg    <= len_next;
      result_reg <= result_next;
    end
  end

  assign busy_o   = (state_reg == TSC_RUN);
  // done marks the completion edge itself, so flag and idle land together
  assign done_o   = done_next;
  assign result_o = result_reg;

endmodule // tsc_conv

// ---- verif/tsc_top_assertions.sv ----
// port checker for the thermal sense control block
`timescale 1ns/1ps
module tsc_checker
  import tsc_pkg::*;
(
  // clock and reset
  input wire logic                  mclk_i,
  input wire logic                  resetn_i,
  // register port
  input wire logic [TSC_ADDR_W-1:0] addr_i,
  input wire logic [TSC_DATA_W-1:0] wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire logic [TSC_DATA_W-1:0] rdata_o,
  // sensor and interrupt
  input wire logic                  sense_power_o,
  input wire logic                  sense_sample_o,
  input wire logic                  irq_o
);
  logic ctl_wr;
  logic mapped;
  assign ctl_wr = wr_i && (addr_i == TSC_OFF_CONTROL);
  assign mapped = (addr_i == TSC_OFF_CLOCK_CTRL) ||
                  ((addr_i >= TSC_OFF_COMPARE_TIM) && (addr_i <= TSC_OFF_RESULT));
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  rdata_quiet_a: assert property (rdata_o != 8'h00 |-> $past(rd_i))
    else $error("read data outside the read answer cycle");
  unmapped_zero_a: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
    else $error("unmapped read returned data");
  irq_masked_a: assert property (ctl_wr && !wdata_i[TSC_CTL_IE_BIT] |=> !irq_o)
    else $error("interrupt high with enable cleared");
  flag_clear_a: assert property (wr_i && addr_i == TSC_OFF_STATUS &&
    wdata_i[TSC_STAT_FLAG_BIT] && !sense_sample_o |=> !irq_o)
    else $error("interrupt still high after flag clear");
  power_follow_a: assert property (ctl_wr |=> sense_power_o == $past(wdata_i[0]))
    else $error("sensor power does not follow enable bit");
  busy_cause_a: assert property ($rose(sense_sample_o) |->
    $past(ctl_wr && wdata_i[1:0] == 2'h3))
    else $error("conversion started without trigger");
  irq_cause_a: assert property ($rose(irq_o) |-> $fell(sense_sample_o) || $past(ctl_wr))
    else $error("interrupt rose without completion");
  abort_stop_a: assert property ($fell(sense_power_o) |-> !sense_sample_o)
    else $error("conversion survives disable");
  status_read_a: assert property (rd_i && addr_i == TSC_OFF_STATUS |=>
    rdata_o[0] == $past(sense_sample_o) && rdata_o[7:5] == 3'h0 && rdata_o[3:1] == 3'h0)
    else $error("status read wrong");
  cover property ($fell(sense_sample_o) && irq_o);
  cover property ($fell(sense_power_o) && $past(sense_sample_o));
  cover property (rd_i && !mapped);
endmodule // tsc_checker

bind tsc_top tsc_checker chk_u (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sense_power_o(sense_power_o),
  .sense_sample_o(sense_sample_o), .irq_o(irq_o));

// ---- verif/tsc_top_bench.sv ----
// self-checking bench for the thermal sense control block
`timescale 1ns/1ps
module tsc_top_bench;
  import tsc_pkg::*;
  logic                  mclk_i;
  logic                  resetn_i;
  logic [TSC_ADDR_W-1:0] addr_i;
  logic [TSC_DATA_W-1:0] wdata_i;
  logic                  wr_i;
  logic                  rd_i;
  logic [TSC_DATA_W-1:0] rdata_o;
  logic [7:0]            sense_data_i;
  logic                  sense_power_o;
  logic                  sense_sample_o;
  logic                  irq_o;
  logic [7:0]            osc_cnt;
  int                    ph6;
  int                    cyc = 0;
  int                    seed;
  int                    fail_count = 0;
  int                    cmp_count = 0;
  logic [15:0]           regs [5] = '{TSC_OFF_CLOCK_CTRL, TSC_OFF_COMPARE_TIM,
                                      TSC_OFF_CONTROL, TSC_OFF_STATUS, TSC_OFF_RESULT};

  tsc_top dut_u (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fast_osc_a_i(ph6 >= 3),
    .fast_osc_b_i(osc_cnt[1]), .slow_osc_i(osc_cnt[3]), .sense_data_i(sense_data_i),
    .sense_power_o(sense_power_o), .sense_sample_o(sense_sample_o), .irq_o(irq_o));

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // oscillators of period 6, 4 and 16 clocks, and the hang limit
  always @(posedge mclk_i) begin
    osc_cnt <= osc_cnt + 8'h01;
    ph6 <= (ph6 == 5) ? 0 : ph6 + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
    @(posedge mclk_i);
  endtask

  initial begin
    logic [7:0] data;
    logic [1:0] s;
    logic [1:0] v;
    logic       ie;
    int         n;
    int         dv;
    int         p;
    int         d;
    seed = 32'h085c51bf;
    resetn_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    sense_data_i = 8'h00;
    osc_cnt = 8'h00;
    ph6 = 0;
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    for (int i = 0; i < 5; i++) rchk(regs[i], 8'h00);
    rchk(16'h51A4, 8'h00);
    wr(TSC_OFF_CLOCK_CTRL, 8'hFF);
    rchk(TSC_OFF_CLOCK_CTRL, 8'h3D);
    wr(TSC_OFF_COMPARE_TIM, 8'hFF);
    rchk(TSC_OFF_COMPARE_TIM, 8'hFF);
    wr(TSC_OFF_CONTROL, 8'hFE);
    rchk(TSC_OFF_CONTROL, 8'h10);
    rchk(TSC_OFF_STATUS, 8'h00);
    wr(TSC_OFF_RESULT, 8'hAA);
    rchk(TSC_OFF_RESULT, 8'h00);
    // reserved source gives no clock, so only an abort ends it
    wr(TSC_OFF_CONTROL, 8'h03);
    repeat (40) @(posedge mclk_i);
    chk({7'h0, sense_sample_o}, 8'h01);
    wr(TSC_OFF_CONTROL, 8'h00);
    chk({7'h0, sense_sample_o}, 8'h00);
    rchk(TSC_OFF_STATUS, 8'h00);
    for (int i = 0; i < 9; i++) begin
      s = 2'(i % 3);
      v = 2'(i / 3);
      n = i % 4;
      ie = i[0];
      dv = (s == TSC_SRC_SLOW) ? 1 : (v == TSC_DIV_4) ? 4 : (v == TSC_DIV_2) ? 2 : 1;
      p = (s == TSC_SRC_SLOW) ? 16 : (s == TSC_SRC_FAST_A) ? 6 : 4;
      data = 8'($random(seed));
      sense_data_i <= data;
      wr(TSC_OFF_CLOCK_CTRL, {2'h0, v, s, 2'h1});
      wr(TSC_OFF_COMPARE_TIM, 8'(n));
      wr(TSC_OFF_CONTROL, {3'h0, ie, 4'h3});
      #1;
      d = 1;
      while (sense_sample_o === 1'b1 && d < 2000) begin
        @(posedge mclk_i);
        #1;
        d++;
      end
      chk(8'(d >= n * p * dv && d <= (n + 1) * p * dv + 8), 8'h01);
      chk({7'h0, irq_o}, {7'h0, ie});
      @(posedge mclk_i);
      rchk(TSC_OFF_STATUS, 8'h10);
      rchk(TSC_OFF_RESULT, data);
      wr(TSC_OFF_STATUS, 8'h00);
      rchk(TSC_OFF_STATUS, 8'h10);
      if (!ie) begin
        wr(TSC_OFF_CONTROL, 8'h10);
        chk({7'h0, irq_o}, 8'h01);
      end
      wr(TSC_OFF_STATUS, 8'h10);
      chk({7'h0, irq_o}, 8'h00);
      rchk(TSC_OFF_STATUS, 8'h00);
    end
    give_verdict();
  end
endmodule // tsc_top_bench
